// *** lwu_cfg.svh ***
// register offsets, field masks, reset values and mode codes of the wake unit
`ifndef LWU_CFG_SVH
`define LWU_CFG_SVH

`define LWU_ADDR_W        8
`define LWU_OFF_PIN_EN    8'h00
`define LWU_OFF_MOD_EN    8'h04
`define LWU_OFF_PIN_FLAG  8'h08
`define LWU_OFF_MOD_FLAG  8'h0c
`define LWU_OFF_CFG       8'h10
`define LWU_OFF_STAT      8'h14
`define LWU_OFF_ACK       8'h18

`define LWU_PIN_VALID     32'h1c00ffff
`define LWU_MOD_VALID     8'ha3
`define LWU_PIN_USB_VDD   26
`define LWU_PIN_USB_DP    27
`define LWU_PIN_USB_DM    28
`define LWU_MOD_LOW_POWER_TIMER     0
`define LWU_MOD_ANALOG_COMPARATOR_ZERO      1
`define LWU_MOD_RTC_ALARM 5
`define LWU_MOD_RTC_SEC   7
`define LWU_CFG_USB_HOST  0
`define LWU_CFG_POR_OFF   1
`define LWU_CFG_MASK      32'h00000003
`define LWU_ACK_BIT       0

`define LWU_RST_PIN_EN    32'h00000000
`define LWU_RST_MOD_EN    8'h00
`define LWU_RST_CFG       2'h0

`define LWU_RESP_OKAY     2'h0
`define LWU_RESP_SLVERR   2'h2

`define LWU_MD_RUN        3'h0
`define LWU_MD_RET_FULL   3'h1
`define LWU_MD_RET_PART   3'h2
`define LWU_MD_VLL3       3'h3
`define LWU_MD_VLL2       3'h4
`define LWU_MD_VLL1       3'h5
`define LWU_MD_VLL0       3'h6
`define LWU_MD_BATT       3'h7

`endif

// *** lwu_pkg.sv ***
// types shared by the wake unit: power modes and controller states
`include "lwu_cfg.svh"
package lwu_pkg;
	typedef enum logic [2:0] {
		md_run                         = `LWU_MD_RUN,
		md_retention_stop_full_sram    = `LWU_MD_RET_FULL,
		md_retention_stop_partial_sram = `LWU_MD_RET_PART,
		md_vll_stop_sram_kept          = `LWU_MD_VLL3,
		md_vll_stop_partial_sram       = `LWU_MD_VLL2,
		md_vll_stop_no_sram            = `LWU_MD_VLL1,
		md_vll_stop_deepest            = `LWU_MD_VLL0,
		md_battery_backup              = `LWU_MD_BATT
	} lwu_mode_e;

	typedef enum logic [3:0] {
		st_idle    = 4'h1,
		st_arm_ret = 4'h2,
		st_arm_vll = 4'h4,
		st_vll_rcv = 4'h8
	} lwu_state_e;
endpackage : lwu_pkg

// *** lwu_pmc_model.sv ***
// power controller model: takes mode commands from the bench and leaves stop on a wake request
`timescale 1ns/1ps
`default_nettype none
module lwu_pmc_model
	import lwu_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// commands from the bench
	input  wire lwu_mode_e  cmd_mode,
	input  wire logic       cmd_go,
	input  wire logic [7:0] exit_delay,
	// wake unit side
	input  wire logic       wake_req,
	output var lwu_mode_e   pmc_mode
);
	logic [7:0] cnt;
	wire        in_stop = (pmc_mode != md_run) && (pmc_mode != md_battery_backup);

	////////////////////////////////////////////////////////////////////////////////
	// exit delay lets the bench model both a prompt and a slow controller
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pmc_mode <= md_run;
			cnt      <= 8'h00;
		end else if (cmd_go) begin
			pmc_mode <= cmd_mode;
			cnt      <= 8'h00;
		end else if (in_stop && wake_req) begin
			// a wake request or a bench command (cmd_go, which wins) ends a low-leakage stop
			// its interrupt is taken as unmasked, so every exit completes
			if (cnt >= exit_delay) begin
				pmc_mode <= md_run;
				cnt      <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end
endmodule : lwu_pmc_model
`default_nettype wire

// *** lwu_wake_unit.sv ***
// leakage_wake_unit: low-leakage stop wakeup and power domain control
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lwu_cfg.svh"

// Behaviour
// R1 - detect wakes only after entering retention or very-low-leakage stop
// R2 - on leaving retention stop, disable immediately and stop detecting
// R3 - after very-low-leakage stop, keep detecting until software acknowledges
// R4 - pin inputs 0..15 are port pins; 16..25 and 29..31 never wake
// R5 - module inputs: 0 timer, 1 comparator, 5 rtc alarm, 7 rtc seconds
// R6 - pin 26 is usb supply detect, 27 d-plus, 28 d-minus
// R7 - interrupt controller disabled in both stop families; only this unit wakes
// R8 - software keeps this unit's interrupt unmasked in the interrupt controller
// R9 - retention stop: peripherals clock-stopped, low-power peripherals stay usable
// R10 - retention full: all sram kept, io held; partial: part of upper
// R11 - vll sram kept: upper and lower on; partial: lower off, upper part
// R12 - vll no-sram and deepest: sram off, both register files stay powered
// R13 - only in deepest vll stop may the por detector be switched off; the unit also switches it off in battery backup
// R14 - battery backup: only rtc and backup register file powered
// R15 - module flag wakes only if enabled; clears via the peripheral
// R16 - usb d-plus and d-minus wakes only in usb host mode
// R17 - enabled active input sets its flag and raises one wake request
module lwu_wake_unit
	import lwu_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// power controller
	input  wire lwu_mode_e   pmc_mode,
	output logic             wake_req,
	// wake pins
	input  wire logic [15:0] wake_pin,
	input  wire logic        usb_supply_detect,
	input  wire logic        usb_dplus_line,
	input  wire logic        usb_dminus_line,
	// peripheral flags, irq_ok order: timer, comparator, alarm, seconds
	input  wire logic        low_power_timer_flag,
	input  wire logic        analog_comparator_zero_flag,
	input  wire logic        rtc_alarm_flag,
	input  wire logic        rtc_seconds_flag,
	input  wire logic [3:0]  periph_irq_ok,
	// power domain controls
	output logic             nested_interrupt_controller_off,
	output logic             sram_upper_on,
	output logic             sram_upper_part_on,
	output logic             sram_lower_on,
	output logic             sysreg_file_on,
	output logic             backup_regs_on,
	output logic             por_detect_on,
	output logic             core_on,
	output logic             periph_clk_on,
	output logic             lp_periph_on,
	output logic             io_hold
);

	////////////////////////////////////////////////////////////////////
	// registers and state
	lwu_state_e  st, next_st;
	logic [31:0] pin_en;
	logic [7:0]  mod_en;
	logic [31:0] pin_flag;
	logic [7:0]  mod_flag;
	logic [1:0]  cfg;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	////////////////////////////////////////////////////////////////////
	// mode decode
	wire ret_part = (pmc_mode == md_retention_stop_partial_sram);
	wire is_ret   = (pmc_mode == md_retention_stop_full_sram) || ret_part;
	wire is_vll   = (pmc_mode >= md_vll_stop_sram_kept) && (pmc_mode <= md_vll_stop_deepest);
	wire is_batt  = (pmc_mode == md_battery_backup);
	wire vll2     = (pmc_mode == md_vll_stop_partial_sram);
	wire vll0     = (pmc_mode == md_vll_stop_deepest);
	wire vll_nosr = (pmc_mode == md_vll_stop_no_sram) || vll0;
	wire armed    = (st == st_arm_ret) || (st == st_arm_vll);
	// the vll recovery state keeps listening until the ack arrives
	wire det_on   = armed || (st == st_vll_rcv);                        // [R1] [R3]

	////////////////////////////////////////////////////////////////////
	// wake sources
	wire usb_host = cfg[`LWU_CFG_USB_HOST];
	wire [31:0] pin_src = {3'h0,
		usb_dminus_line & usb_host,                                     // [R6] [R16]
		usb_dplus_line & usb_host,                                      // [R6] [R16]
		usb_supply_detect,                                              // [R6]
		10'h000, wake_pin};                                             // [R4]
	wire [7:0] mod_src = {rtc_seconds_flag & periph_irq_ok[3], 1'b0,
		rtc_alarm_flag & periph_irq_ok[2], 3'h0, analog_comparator_zero_flag & periph_irq_ok[1],
		low_power_timer_flag & periph_irq_ok[0]};                       // [R5] [R15]
	wire [31:0] pin_hit = det_on ? (pin_src & pin_en & `LWU_PIN_VALID) : 32'h0; // [R4]
	wire [7:0]  mod_hit = det_on ? (mod_src & mod_en & `LWU_MOD_VALID) : 8'h00; // [R15]

	////////////////////////////////////////////////////////////////////
	// axi4-lite handshakes and decode
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs  = s_axi_wvalid & s_axi_wready;
	wire b_hs  = s_axi_bvalid & s_axi_bready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire r_hs  = s_axi_rvalid & s_axi_rready;
	wire do_wr = aw_got & w_got & ~s_axi_bvalid;
	wire next_aw_got = (aw_got | aw_hs) & ~do_wr;
	wire next_w_got  = (w_got | w_hs) & ~do_wr;
	wire next_bvalid = (s_axi_bvalid & ~b_hs) | do_wr;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] wbits = w_data & wmask;
	wire wr_pin_en = do_wr && (aw_addr == `LWU_OFF_PIN_EN);
	wire wr_mod_en = do_wr && (aw_addr == `LWU_OFF_MOD_EN);
	wire wr_pflag  = do_wr && (aw_addr == `LWU_OFF_PIN_FLAG);
	wire wr_cfg    = do_wr && (aw_addr == `LWU_OFF_CFG);
	wire ack_p     = do_wr && (aw_addr == `LWU_OFF_ACK) && wbits[`LWU_ACK_BIT];
	wire wr_ok = (aw_addr <= `LWU_OFF_ACK) && (aw_addr[1:0] == 2'h0) &&
		(aw_addr != `LWU_OFF_MOD_FLAG) && (aw_addr != `LWU_OFF_STAT);
	// the read decode looks only at the read address, never at the last write
	wire rd_ok = (s_axi_araddr <= `LWU_OFF_ACK) && (s_axi_araddr[1:0] == 2'h0);
	wire [31:0] stat_word = {23'h0, wake_req, 1'b0, pmc_mode, st};
	wire [31:0] rd_word =
		(s_axi_araddr == `LWU_OFF_PIN_EN)   ? pin_en :
		(s_axi_araddr == `LWU_OFF_MOD_EN)   ? {24'h0, mod_en} :
		(s_axi_araddr == `LWU_OFF_PIN_FLAG) ? pin_flag :
		(s_axi_araddr == `LWU_OFF_MOD_FLAG) ? {24'h0, mod_flag} :
		(s_axi_araddr == `LWU_OFF_CFG)      ? {30'h0, cfg} :
		(s_axi_araddr == `LWU_OFF_STAT)     ? stat_word : 32'h0;
	// an ack read back as zero; it is a strobe, not storage
	wire rd_valid_addr = rd_ok && (s_axi_araddr != `LWU_OFF_ACK);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LWU_RESP_OKAY;
		end else begin
			aw_got        <= next_aw_got;
			w_got         <= next_w_got;
			s_axi_awready <= ~next_aw_got & ~next_bvalid;
			s_axi_wready  <= ~next_w_got & ~next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (aw_hs) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bresp <= wr_ok ? `LWU_RESP_OKAY : `LWU_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `LWU_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_valid_addr ? `LWU_RESP_OKAY : `LWU_RESP_SLVERR;
		end else begin
			s_axi_rvalid  <= s_axi_rvalid & ~r_hs;
			s_axi_arready <= ~s_axi_rvalid | r_hs;
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers and flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_en <= `LWU_RST_PIN_EN;
			mod_en <= `LWU_RST_MOD_EN;
			cfg    <= `LWU_RST_CFG;
		end else begin
			if (wr_pin_en) begin
				pin_en <= ((pin_en & ~wmask) | wbits) & `LWU_PIN_VALID;  // [R4]
			end
			if (wr_mod_en) begin
				mod_en <= ((mod_en & ~wmask[7:0]) | wbits[7:0]) & `LWU_MOD_VALID;
			end
			if (wr_cfg) begin
				cfg <= (cfg & ~wmask[1:0]) | wbits[1:0];
			end
		end
	end

	// set wins over a write-one-to-clear in the same cycle
	wire [31:0] pflag_clr = wr_pflag ? wbits : 32'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_flag <= 32'h0;
			mod_flag <= 8'h00;
		end else begin
			pin_flag <= (pin_flag & ~pflag_clr) | pin_hit;             // [R17]
			mod_flag <= (mod_flag & mod_src) | mod_hit;                // [R15] [R17]
		end
	end

	////////////////////////////////////////////////////////////////////
	// controller state
	always_comb begin
		next_st = st;
		case (st)
			st_idle: begin
				if (is_ret) begin
					next_st = st_arm_ret;                                 // [R1]
				end else if (is_vll) begin
					next_st = st_arm_vll;                                 // [R1]
				end
			end
			st_arm_ret: begin
				if (!is_ret) begin
					next_st = st_idle;                                    // [R2]
				end
			end
			st_arm_vll: begin
				if (!is_vll) begin
					next_st = st_vll_rcv;                                 // [R3]
				end
			end
			st_vll_rcv: begin
				if (ack_p) begin
					next_st = st_idle;                                    // [R3]
				end else if (is_vll) begin
					next_st = st_arm_vll;
				end
			end
			default: next_st = st_idle;
		endcase
	end

	// the request is raised only from an armed state, so it stays up one cycle past a vll exit
	wire next_wake = armed && (next_st != st_idle) &&
		((|pin_hit) || (|mod_hit) || (|pin_flag) || (|mod_flag));       // [R17]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st       <= st_idle;
			wake_req <= 1'b0;
		end else begin
			st       <= next_st;
			wake_req <= next_wake;
		end
	end

	////////////////////////////////////////////////////////////////////
	// power domains per mode
	wire stop_any = is_ret | is_vll;
	wire next_nic_off = stop_any;                                       // [R7]
	wire next_sram_u  = ~(ret_part | vll2 | vll_nosr | is_batt);        // [R10] [R11]
	wire next_sram_up = ~(vll_nosr | is_batt);                          // [R10] [R11] [R12]
	wire next_sram_l  = ~(ret_part | vll2 | vll_nosr | is_batt);        // [R11] [R12]
	wire next_sysreg  = ~is_batt;                                       // [R12]
	wire next_por     = ~(is_batt | (vll0 & cfg[`LWU_CFG_POR_OFF]));    // [R13]
	wire next_core    = ~is_batt;                                       // [R14]
	wire next_pclk    = ~(stop_any | is_batt);                          // [R9]
	wire next_lp      = ~is_batt;                                       // [R9]
	wire next_hold    = stop_any;                                       // [R10]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nested_interrupt_controller_off <= 1'b0;
			sram_upper_on      <= 1'b1;
			sram_upper_part_on <= 1'b1;
			sram_lower_on      <= 1'b1;
			sysreg_file_on     <= 1'b1;
			backup_regs_on     <= 1'b1;
			por_detect_on      <= 1'b1;
			core_on            <= 1'b1;
			periph_clk_on      <= 1'b1;
			lp_periph_on       <= 1'b1;
			io_hold            <= 1'b0;
		end else begin
			nested_interrupt_controller_off <= next_nic_off;
			sram_upper_on      <= next_sram_u;
			sram_upper_part_on <= next_sram_up;
			sram_lower_on      <= next_sram_l;
			sysreg_file_on     <= next_sysreg;
			backup_regs_on     <= 1'b1;                                  // [R12] [R14]
			por_detect_on      <= next_por;
			core_on            <= next_core;
			periph_clk_on      <= next_pclk;
			lp_periph_on       <= next_lp;
			io_hold            <= next_hold;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	a_wake_only_stop: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		wake_req |-> $past(armed)) else $error("wake request outside stop");
	a_ret_exit_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(st == st_arm_ret) && !is_ret |=> (st == st_idle) && !wake_req)
		else $error("unit still active after retention exit");
	a_vll_keep_det: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(st == st_vll_rcv) && !ack_p |=> (st != st_idle))
		else $error("vll recovery ended without ack");
	a_reserved_pins: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		$rose(|(pin_flag & ~`LWU_PIN_VALID)) |-> 1'b0) else $error("reserved pin flag set");
	a_timer_map: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		$rose(mod_flag[`LWU_MOD_LOW_POWER_TIMER]) |-> $past(low_power_timer_flag &&
		periph_irq_ok[0] && mod_en[`LWU_MOD_LOW_POWER_TIMER] && det_on))
		else $error("timer flag without enabled source");
	a_usb_supply: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		det_on && usb_supply_detect && pin_en[`LWU_PIN_USB_VDD]
		|=> pin_flag[`LWU_PIN_USB_VDD]) else $error("usb supply wake lost");
	a_nic_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		(is_ret || is_vll) |=> nested_interrupt_controller_off)
		else $error("interrupt controller left on in stop");
	a_ret_periph: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
		is_ret |=> !periph_clk_on && lp_periph_on)
		else $error("retention peripheral domains wrong");
	a_ret_part_sram: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		ret_part |=> sram_upper_part_on && !sram_upper_on && !sram_lower_on && io_hold)
		else $error("retention partial sram wrong");
	a_vll_sram: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		vll2 |=> !sram_lower_on && sram_upper_part_on && !sram_upper_on)
		else $error("vll partial sram wrong");
	a_regfile_kept: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		vll_nosr |=> !sram_upper_part_on && sysreg_file_on && backup_regs_on)
		else $error("register files not kept");
	a_por_only_deep: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
		!vll0 && !is_batt |=> por_detect_on) else $error("por off outside deepest");
	a_battery_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
		is_batt |=> !core_on && !sysreg_file_on && backup_regs_on)
		else $error("battery backup domains wrong");
	a_usb_host_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		!usb_host |=> !$rose(pin_flag[`LWU_PIN_USB_DP]) && !$rose(pin_flag[`LWU_PIN_USB_DM]))
		else $error("usb line wake outside host mode");
	a_hit_to_req: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
		armed && (next_st != st_idle) && (|pin_hit) |=> wake_req ##0 pin_flag != 32'h0)
		else $error("enabled wake did not raise request");

endmodule : lwu_wake_unit
`default_nettype wire

// *** lwu_wake_unit_bench.sv ***
// self-checking bench for the wake unit with a power controller model
`timescale 1ns/1ps
`default_nettype none
module lwu_wake_unit_bench
	import lwu_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd_data;
	lwu_mode_e   pmc_mode, cmd_mode = md_run;
	logic        cmd_go = 1'b0;
	logic [7:0]  exit_delay = 8'h01;
	logic [15:0] wake_pin = 16'h0;
	logic        usb_supply_detect = 1'b0, usb_dplus_line = 1'b0, usb_dminus_line = 1'b0;
	logic [3:0]  mflag = 4'h0, periph_irq_ok = 4'hf;
	logic        wake_req, nested_interrupt_controller_off, sram_upper_on, sram_upper_part_on;
	logic        sram_lower_on, sysreg_file_on, backup_regs_on, por_detect_on;
	logic        periph_clk_on, lp_periph_on, core_on, io_hold;
	int          fails = 0, compares = 0;
	// upper, upper part, lower, sysreg, backup, ic off, periph clk, lp periph, por
	logic [8:0]  dom_exp [0:7] = '{9'h1f7, 9'h1fb, 9'h0bb, 9'h1fb, 9'h0bb, 9'h03b, 9'h03a, 9'h010};
	logic [7:0]  mod_exp [0:3] = '{8'h01, 8'h02, 8'h20, 8'h80};
	wire  [8:0]  dom_got = {sram_upper_on, sram_upper_part_on, sram_lower_on, sysreg_file_on,
		backup_regs_on, nested_interrupt_controller_off, periph_clk_on, lp_periph_on, por_detect_on};

	always #4 aclk = ~aclk;

	lwu_wake_unit dut (
		.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pmc_mode, .wake_req,
		.wake_pin, .usb_supply_detect, .usb_dplus_line, .usb_dminus_line,
		.low_power_timer_flag(mflag[0]), .analog_comparator_zero_flag(mflag[1]),
		.rtc_alarm_flag(mflag[2]), .rtc_seconds_flag(mflag[3]), .periph_irq_ok,
		.nested_interrupt_controller_off, .sram_upper_on, .sram_upper_part_on, .sram_lower_on,
		.sysreg_file_on, .backup_regs_on, .por_detect_on, .core_on, .periph_clk_on,
		.lp_periph_on, .io_hold
	);

	lwu_pmc_model far (.aclk, .aresetn, .cmd_mode, .cmd_go, .exit_delay, .wake_req, .pmc_mode);

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (fails == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_data = s_axi_rdata;
		resp    = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, rd_data);
	endtask : rdchk

	// domain outputs follow the mode one edge after the model takes it
	task automatic set_mode(input lwu_mode_e m);
		cmd_mode <= m;
		cmd_go   <= 1'b1;
		@(posedge aclk);
		cmd_go   <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : set_mode

	task automatic wait_run();
		while (pmc_mode !== md_run) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask : wait_run

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdchk("pin_en", 8'h00, 32'h0);
		wr(8'h00, 32'hffffffff);
		chk("bresp", 32'h0, {30'h0, resp});
		rdchk("pin_en", 8'h00, 32'h1c00ffff);
		wr(8'h04, 32'hffffffff);
		rdchk("mod_en", 8'h04, 32'h000000a3);
		rd(8'h1c);
		chk("unmapped resp", 32'h2, {30'h0, resp});
		wr(8'h1c, 32'h0);
		chk("unmapped bresp", 32'h2, {30'h0, resp});
		rdchk("ack", 8'h18, 32'h0);
		// pins are ignored while running
		wake_pin <= 16'h0008;
		repeat (3) @(posedge aclk);
		chk("wake_req", 32'h0, {31'h0, wake_req});
		rdchk("pin_flag", 8'h08, 32'h0);
		wake_pin <= 16'h0000;
		wr(8'h10, 32'h2);
		for (int i = 0; i < 8; i++) begin
			set_mode(lwu_mode_e'(i[2:0]));
			chk("domains", {23'h0, dom_exp[i]}, {23'h0, dom_got & ((i == 7) ? 9'h1f6 : 9'h1ff)});
			chk("core_hold", {30'h0, (i != 7), (i > 0 && i < 7)}, {30'h0, core_on, io_hold});
		end
		wr(8'h10, 32'h0);
		set_mode(md_vll_stop_deepest);
		chk("por", 32'h1, {31'h0, por_detect_on});
		set_mode(md_run);
		wr(8'h18, 32'h1);
		rdchk("status", 8'h14, 32'h01);
		// retention stop with a slow controller: detection ends on exit
		exit_delay <= 8'd40;
		set_mode(md_retention_stop_full_sram);
		rdchk("status", 8'h14, 32'h12);
		wake_pin <= 16'h0008;
		repeat (2) @(posedge aclk);
		chk("wake_req", 32'h1, {31'h0, wake_req});
		rdchk("pin_flag", 8'h08, 32'h8);
		wait_run();
		chk("wake_req", 32'h0, {31'h0, wake_req});
		wake_pin <= 16'h0020;
		wr(8'h08, 32'hffffffff);
		rdchk("pin_flag", 8'h08, 32'h0);
		rdchk("status", 8'h14, 32'h01);
		wake_pin <= 16'h0000;
		// very-low-leakage stop, prompt controller, usb lines outside then inside host mode
		exit_delay <= 8'd1;
		usb_dplus_line <= 1'b1;
		set_mode(md_vll_stop_sram_kept);
		usb_supply_detect <= 1'b1;
		wait_run();
		rdchk("status", 8'h14, 32'h08);
		rdchk("pin_flag", 8'h08, 32'h04000000);
		wake_pin <= 16'h0080;
		repeat (2) @(posedge aclk);
		rdchk("pin_flag", 8'h08, 32'h04000080);
		wr(8'h18, 32'h1);
		rdchk("status", 8'h14, 32'h01);
		usb_supply_detect <= 1'b0;
		usb_dminus_line <= 1'b1;
		wake_pin <= 16'h0000;
		wr(8'h08, 32'hffffffff);
		wr(8'h10, 32'h1);
		set_mode(md_vll_stop_partial_sram);
		wait_run();
		rdchk("pin_flag", 8'h08, 32'h18000000);
		wr(8'h18, 32'h1);
		usb_dplus_line <= 1'b0;
		usb_dminus_line <= 1'b0;
		wr(8'h08, 32'hffffffff);
		// each module flag: refused without its interrupt, then wakes and clears with the source
		for (int k = 0; k < 4; k++) begin
			periph_irq_ok <= 4'hf ^ (4'h1 << k);
			mflag <= 4'h1 << k;
			set_mode(md_vll_stop_no_sram);
			@(posedge aclk);
			chk("wake_req", 32'h0, {31'h0, wake_req});
			periph_irq_ok <= 4'hf;
			wait_run();
			rdchk("mod_flag", 8'h0c, {24'h0, mod_exp[k]});
			mflag <= 4'h0;
			repeat (2) @(posedge aclk);
			rdchk("mod_flag", 8'h0c, 32'h0);
			wr(8'h18, 32'h1);
		end
		end_sim();
	end

	// whole run is well under two thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		end_sim();
	end
endmodule : lwu_wake_unit_bench
`default_nettype wire
